// *** include/esp_pkg.sv ***
// Shared constants, types and helpers for the EEPROM serial slave port
package esp_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_US = 5000;
    localparam int NS_PER_US = 1000;
    localparam int PROG_CYCLES_DFLT =
        (PROG_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 20;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int MEM_BYTES = 256;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_W = 4;
    localparam int FIFO_DEPTH = 16;

    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int RW_BIT = 0;
    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] DEV_TYPE_DFLT = 4'ha;

    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] PAGE_NONE = 16'h0000;

    typedef struct packed {
        logic scl;
        logic sda;
    } esp_bus_s;

    localparam esp_bus_s BUS_IDLE = '{scl: 1'b1, sda: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } esp_state_e;

    typedef enum logic [1:0] {
        KIND_ADDR,
        KIND_WORD,
        KIND_DATA
    } esp_kind_e;

    // Advance only the in-page bits of a byte address
    function automatic logic [7:0] esp_page_inc(input logic [7:0] a);
        return {a[7:PAGE_W], a[PAGE_W-1:0] + 4'h1};
    endfunction

    // Advance the full byte address, wrapping at the top of the array
    function automatic logic [7:0] esp_full_inc(input logic [7:0] a);
        return a + 8'h01;
    endfunction

endpackage

// *** logic/esp_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module esp_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    import esp_pkg::*;

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            stage1 <= RESET_VAL;
            q_o <= RESET_VAL;
        end else if (ce_i) begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule

// *** logic/esp_fifo.sv ***
// Parameterised FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
module esp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    import esp_pkg::*;

    // Depth is expected to be a power of two so the pointers wrap freely
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != FULL_COUNT);
    assign out_valid_o = (count != '0);
    assign out_data_o = store[rd_ptr];
    assign push = in_valid_i & in_ready_o & ~flush_i;
    assign pop = out_valid_o & out_ready_i & ~flush_i;

    always_ff @(posedge clock_i) begin
        if (ce_i && push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce_i) begin
            if (flush_i) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                if (push && !pop) begin
                    count <= count + 1'b1;
                end else if (pop && !push) begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// *** logic/esp_top.sv ***
// Serial bus slave port of a 2-kbit EEPROM with page buffer and array
`timescale 1ns/1ps
module esp_top #(
    parameter int PROG_CYCLES = esp_pkg::PROG_CYCLES_DFLT,
    parameter logic [3:0] DEV_TYPE = esp_pkg::DEV_TYPE_DFLT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic sup_reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o
);
    import esp_pkg::*;

    localparam logic [PROG_CNT_W-1:0] PROG_LAST =
        PROG_CNT_W'(PROG_CYCLES - 1);

    esp_bus_s bus_raw;
    esp_bus_s bus_s;
    esp_bus_s bus_q;
    esp_state_e state;
    esp_kind_e kind;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx_shift;
    logic rw;
    logic ack_ok;
    logic mack_ok;
    logic sda_drive;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];
    logic [15:0] page_vld;
    logic [7:0] addr_cnt;
    logic [7:0] pf_addr;
    logic pf_on;
    logic [PROG_CNT_W-1:0] prog_cnt;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic [7:0] rx_byte;
    logic addr_match;
    logic rd_match;
    logic tx_load;
    logic [7:0] tx_byte;
    logic commit;
    logic fifo_flush;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    assign bus_raw = '{scl: scl_i, sda: sda_i};

    esp_sync #(
        .WIDTH($bits(esp_bus_s)),
        .RESET_VAL(BUS_IDLE)
    ) u_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i(bus_raw),
        .q_o(bus_s)
    );

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus_q <= BUS_IDLE;
        end else if (ce_i) begin
            bus_q <= bus_s;
        end
    end

    assign scl_rise = bus_s.scl & ~bus_q.scl;
    assign scl_fall = ~bus_s.scl & bus_q.scl;
    assign start_det = bus_s.scl & bus_q.scl & bus_q.sda & ~bus_s.sda;
    assign stop_det = bus_s.scl & bus_q.scl & ~bus_q.sda & bus_s.sda;

    assign byte_done = (state == ST_RX) && scl_rise && (bit_cnt == BIT_LAST);
    assign rx_byte = {shreg[6:0], bus_s.sda};
    assign addr_match = (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE) &&
                        !busy_o && !sup_reset_i;
    assign rd_match = byte_done && (kind == KIND_ADDR) && addr_match &&
                      (rx_byte[RW_BIT] == RW_READ);
    assign tx_load = scl_fall && !sup_reset_i &&
                     (((state == ST_ACK) && (rw == RW_READ)) ||
                      ((state == ST_MACK) && mack_ok));
    assign tx_byte = fifo_out_valid ? fifo_out_data : ERASED_BYTE;
    // programming starts at stop after write
    assign commit = stop_det && !sup_reset_i && (rw != RW_READ) &&
                    (page_vld != PAGE_NONE) && !busy_o;
    assign fifo_flush = start_det | stop_det | sup_reset_i | rd_match;

    // Open-drain data line: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_drive;

    // Bus protocol state machine
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            kind <= KIND_ADDR;
            bit_cnt <= BIT_FIRST;
            shreg <= BYTE_ZERO;
            tx_shift <= BYTE_ZERO;
            rw <= 1'b0;
            ack_ok <= 1'b0;
            mack_ok <= 1'b0;
            sda_drive <= 1'b0;
        end else if (ce_i) begin
            if (sup_reset_i) begin
                state <= ST_IDLE;
                sda_drive <= 1'b0;
            end else if (start_det) begin
                state <= ST_RX;
                kind <= KIND_ADDR;
                bit_cnt <= BIT_FIRST;
                sda_drive <= 1'b0;
            end else if (stop_det) begin
                state <= ST_IDLE;
                sda_drive <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done) begin
                            case (kind)
                                KIND_ADDR: begin
                                    ack_ok <= addr_match;
                                    rw <= rx_byte[RW_BIT];
                                    kind <= (rx_byte[RW_BIT] == RW_READ) ?
                                            KIND_DATA : KIND_WORD;
                                end
                                default: begin
                                    ack_ok <= 1'b1;
                                    kind <= KIND_DATA;
                                end
                            endcase
                        end else if (scl_fall && (bit_cnt > BIT_LAST)) begin
                            state <= ack_ok ? ST_ACK : ST_IGNORE;
                            sda_drive <= ack_ok;
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= BIT_FIRST;
                            if (rw == RW_READ) begin
                                state <= ST_TX;
                                tx_shift <= tx_byte;
                                sda_drive <= ~tx_byte[7];
                            end else begin
                                state <= ST_RX;
                                sda_drive <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        // shift out eight bits then release
                        if (scl_fall) begin
                            if (bit_cnt == BIT_LAST) begin
                                state <= ST_MACK;
                                sda_drive <= 1'b0;
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                sda_drive <= ~tx_shift[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_ok <= ~bus_s.sda;
                        end
                        if (scl_fall) begin
                            bit_cnt <= BIT_FIRST;
                            if (mack_ok) begin
                                state <= ST_TX;
                                tx_shift <= tx_byte;
                                sda_drive <= ~tx_byte[7];
                            end else begin
                                state <= ST_IGNORE;
                                sda_drive <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        sda_drive <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Address counter and page buffer
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            addr_cnt <= BYTE_ZERO;
            page_vld <= PAGE_NONE;
        end else if (ce_i) begin
            if (sup_reset_i || commit || (start_det && !busy_o)) begin
                page_vld <= PAGE_NONE;
            end else if (byte_done && (kind == KIND_WORD)) begin
                addr_cnt <= rx_byte;
                page_vld <= PAGE_NONE;
            end else if (byte_done && (kind == KIND_DATA) &&
                         (rw != RW_READ)) begin
                page_buf[addr_cnt[PAGE_W-1:0]] <= rx_byte;
                page_vld[addr_cnt[PAGE_W-1:0]] <= 1'b1;
                addr_cnt <= esp_page_inc(addr_cnt);
            end else if (tx_load) begin
                // counter holds last read plus one
                addr_cnt <= esp_full_inc(addr_cnt);
            end
        end
    end

    // Read prefetch into the FIFO
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pf_on <= 1'b0;
            pf_addr <= BYTE_ZERO;
        end else if (ce_i) begin
            if (rd_match) begin
                // read starts at the current address
                // restart read uses the dummy-write address
                pf_on <= 1'b1;
                pf_addr <= addr_cnt;
            end else if (fifo_flush || (state == ST_IGNORE)) begin
                pf_on <= 1'b0;
            end else if (pf_on && fifo_in_ready) begin
                // prefetch wraps across the whole array
                pf_addr <= esp_full_inc(pf_addr);
            end
        end
    end

    esp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .flush_i(fifo_flush),
        .in_valid_i(pf_on),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem[pf_addr]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(tx_load),
        .out_data_o(fifo_out_data)
    );

    // Array contents; erased state after reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem[i] <= ERASED_BYTE;
            end
        end else if (ce_i && commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_vld[i]) begin
                    mem[{addr_cnt[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
                        page_buf[i];
                end
            end
        end
    end

    // Internal programming timer; runs on through supervisor reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
            prog_cnt <= '0;
        end else if (ce_i) begin
            if (commit) begin
                busy_o <= 1'b1;
                prog_cnt <= '0;
            end else if (busy_o) begin
                if (prog_cnt == PROG_LAST) begin
                    busy_o <= 1'b0;
                end else begin
                    prog_cnt <= prog_cnt + 1'b1;
                end
            end
        end
    end
endmodule

// *** tb/esp_props.sv ***
// Concurrent checks on the serial slave port pins
`timescale 1ns/1ps
module esp_props #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic sup_reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic busy_o
);
    int busy_cnt;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // Counts busy cycles so the write time can be measured
    always_ff @(posedge clock_i) begin
        if (reset_i || !busy_o) begin
            busy_cnt <= 0;
        end else if (ce_i) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    a_reset_quiet: assert property (
        $fell(reset_i) |-> !sda_oe_o && !busy_o) else $error("not idle");
    a_open_drain: assert property (
        sda_oe_o |-> sda_o == 1'b0) else $error("data driven high");
    a_oe_scl_low: assert property (
        $changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
    a_sync_delay: assert property (
        $fell(scl_i) |=> $stable(sda_oe_o) ##1 $stable(sda_oe_o))
        else $error("reacted before synchroniser");
    a_addr_quiet: assert property (
        $fell(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o [*8])
        else $error("drove data after start");
    a_stop_quiet: assert property (
        $rose(sda_i) && scl_i && $past(scl_i) |=> !sda_oe_o [*8])
        else $error("drove data after stop");
    a_sup_release: assert property (
        sup_reset_i |=> !sda_oe_o) else $error("drove data in sup reset");
    a_busy_silent: assert property (
        busy_o |-> !sda_oe_o) else $error("answered while busy");
    a_busy_length: assert property (
        $fell(busy_o) |-> busy_cnt == PROG_CYCLES)
        else $error("write time short");
    a_busy_bound: assert property (
        busy_o |-> busy_cnt < PROG_CYCLES) else $error("write time long");
endmodule

bind esp_top esp_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .sup_reset_i(sup_reset_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .busy_o(busy_o)
);

// *** tb/esp_master.sv ***
// Behavioural bus master that makes the serial clock
`timescale 1ns/1ps
module esp_master (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic bit_x(input logic b, output logic s);
        scl_o <= 1'b0;
        tick(1);
        sda_low_o <= ~b;
        tick(4);
        scl_o <= 1'b1;
        tick(2);
        s = sda_i;
        tick(1);
    endtask

    task automatic cond(input logic st);
        scl_o <= 1'b0;
        tick(1);
        sda_low_o <= ~st;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= st;
        tick(4);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(~mack, s);
    endtask
endmodule

// *** tb/tb_esp_top.sv ***
// Self-checking bench for the EEPROM serial slave port
`timescale 1ns/1ps
module tb_esp_top;
    import esp_pkg::*;
    localparam int PROG = 200;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic sup_reset_i = 1'b0;
    logic ce_i = 1'b1;
    logic scl;
    logic m_low;
    logic sda_w;
    logic sda_o;
    logic sda_oe_o;
    logic busy_o;
    logic ack;
    logic [7:0] d;
    int fail_count = 0;
    int compares = 0;

    always #25 clock_i = ~clock_i;
    assign sda_w = (sda_oe_o ? sda_o : 1'b1) & ~m_low;

    esp_master m_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(m_low));
    esp_top #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV_TYPE_DFLT)) dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i),
        .sup_reset_i(sup_reset_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic e);
        m_u.wbyte(b, ack);
        chk("ack", {7'h0, e}, {7'h0, ack});
    endtask

    task automatic recv(input logic mack, input logic [7:0] e);
        m_u.rbyte(mack, d);
        chk("read data", e, d);
    endtask

    // Dummy write of the pointer, then repeated start for reading
    task automatic point(input logic [7:0] w);
        m_u.cond(1'b1);
        send(8'ha0, 1'b1);
        send(w, 1'b1);
        m_u.cond(1'b1);
        send(8'ha1, 1'b1);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 2000 && busy_o !== 1'b0; n++)
            @(posedge clock_i);
        if (busy_o !== 1'b0) begin
            fail_count++;
            $display("CHECK FAILED busy_o expected 0 seen %b", busy_o);
            end_sim();
        end
    endtask

    task automatic t_byte_write();
        int tries;
        m_u.cond(1'b1);
        send(8'ha0, 1'b1);
        send(8'h00, 1'b1);
        send(8'h5a, 1'b1);
        m_u.cond(1'b0);
        @(posedge clock_i);
        chk("busy", 8'h01, {7'h0, busy_o});
        m_u.cond(1'b1);
        send(8'ha0, 1'b0);
        m_u.cond(1'b0);
        for (tries = 0; tries < 8 && ack !== 1'b1; tries++) begin
            m_u.cond(1'b1);
            m_u.wbyte(8'ha0, ack);
            m_u.cond(1'b0);
        end
        chk("poll", 8'h01, {7'h0, ack});
        chk("busy", 8'h00, {7'h0, busy_o});
        $display("byte write done");
    endtask

    task automatic t_read_wrap();
        point(8'hff);
        recv(1'b0, 8'hff);
        m_u.cond(1'b0);
        m_u.cond(1'b1);
        send(8'ha1, 1'b1);
        recv(1'b0, 8'h5a);
        m_u.cond(1'b0);
        $display("current read done");
    endtask

    task automatic t_page();
        logic [7:0] e [16];
        m_u.cond(1'b1);
        send(8'ha0, 1'b1);
        send(8'h3e, 1'b1);
        for (int i = 0; i < 18; i++) begin
            send(8'h80 + i[7:0], 1'b1);
            e[(14 + i) % 16] = 8'h80 + i[7:0];
        end
        m_u.cond(1'b0);
        wait_idle();
        point(8'h30);
        for (int i = 0; i < 16; i++)
            recv(1'b1, e[i]);
        recv(1'b0, 8'hff);
        m_u.cond(1'b0);
        $display("page write done");
    endtask

    task automatic t_nack();
        point(8'h31);
        recv(1'b0, 8'h83);
        m_u.rbyte(1'b0, d);
        chk("released", 8'hff, d);
        m_u.cond(1'b0);
        $display("nack done");
    endtask

    task automatic t_foreign();
        logic [7:0] a [4] = '{8'h50, 8'hb1, 8'h2e, 8'hae};
        for (int i = 0; i < 4; i++) begin
            m_u.cond(1'b1);
            send(a[i], i == 3);
            if (i < 3) begin
                m_u.rbyte(1'b0, d);
                chk("silent", 8'hff, d);
            end
            m_u.cond(1'b0);
        end
        $display("foreign address done");
    endtask

    task automatic t_sup();
        m_u.cond(1'b1);
        send(8'ha0, 1'b1);
        send(8'h20, 1'b1);
        send(8'hc3, 1'b1);
        m_u.cond(1'b0);
        sup_reset_i <= 1'b1;
        m_u.cond(1'b1);
        send(8'ha0, 1'b0);
        m_u.cond(1'b0);
        wait_idle();
        sup_reset_i <= 1'b0;
        point(8'h20);
        recv(1'b0, 8'hc3);
        m_u.cond(1'b0);
        $display("supervisor reset done");
    endtask

    // Freezing the clock enable must hold the write timer still
    task automatic t_ce();
        m_u.cond(1'b1);
        send(8'ha0, 1'b1);
        send(8'h50, 1'b1);
        send(8'h3c, 1'b1);
        m_u.cond(1'b0);
        ce_i <= 1'b0;
        repeat (300) @(posedge clock_i);
        chk("frozen busy", 8'h01, {7'h0, busy_o});
        ce_i <= 1'b1;
        wait_idle();
        point(8'h50);
        recv(1'b0, 8'h3c);
        m_u.cond(1'b0);
        $display("clock enable done");
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        t_byte_write();
        t_read_wrap();
        t_page();
        t_nack();
        t_foreign();
        t_sup();
        t_ce();
        end_sim();
    end
endmodule
